// ### hdl/rfps_pkg.sv
package rfps_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_AUTOREAD = 6'h01;
  localparam logic [5:0] IDX_HASH_HI = 6'h0E;
  localparam logic [5:0] IDX_HASH_LO = 6'h0F;
  localparam logic [5:0] IDX_FILTER = 6'h10;
  localparam logic [5:0] IDX_CTRL = 6'h11;
  localparam logic [5:0] IDX_STATUS = 6'h12;
  localparam logic [5:0] IDX_INFO_HI = 6'h1D;
  localparam logic [5:0] IDX_INFO_LO = 6'h1E;

  // reset values
  localparam logic [3:0] FILTER_RST = 4'hC;
  localparam logic [7:0] HASH_HI_RST = 8'h04;
  localparam logic [7:0] HASH_LO_RST = 8'h00;

  // rx_filter_config bit positions
  localparam int FILT_DROP_GROUP = 0;
  localparam int FILT_DROP_BROADCAST_FLAG = 1;
  localparam int FILT_DROP_FCS = 2;
  localparam int FILT_DROP_SHORT = 3;

  // control and status bit positions
  localparam int CTRL_FLUSH = 0;
  localparam int CTRL_SKIP = 1;
  localparam int CTRL_RELEASE = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FULLY_READ = 1;

  // frame handling
  localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
  localparam logic [15:0] DEST_BYTES = 16'h0006;
  localparam logic [31:0] CRC_POLY = 32'hC704DD7B;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam int BUF_DEPTH_DEF = 4096;
  localparam int SLOTS_DEF = 8;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } rfps_rx_s;

  // per-frame facts from the MAC core, valid with the eof byte
  typedef struct packed {
    logic fcs_bad;
    logic vlan;
    logic ctrl;
    logic pause;
    logic unsup;
    logic trailing;
    logic type_field;
    logic len_err;
  } rfps_rx_end_s;

  // current_packet_info_high : current_packet_info_low
  typedef struct packed {
    logic slot_occupied;
    logic tagged_frame_seen;
    logic unsupported_ctrl_seen;
    logic pause_frame_seen;
    logic ctrl_frame_seen;
    logic trailing_bits_seen;
    logic broadcast_flag;
    logic group_address_flag;
    logic receive_good;
    logic type_field;
    logic length_mismatch_flag;
    logic fcs_fail_flag;
    logic [1:0] rsvd;
    logic too_short_flag;
    logic frame_lost_flag;
  } rfps_info_s;
endpackage : rfps_pkg

// ### hdl/rfps_crc_byte.sv
`timescale 1ns/1ns
`default_nettype none
module rfps_crc_byte #(
  parameter logic [31:0] POLY = 32'hC704DD7B
) (
  // running value
  input wire logic [31:0] crc_in,
  // byte, least significant bit first
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);
  always_comb begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end
endmodule : rfps_crc_byte
`default_nettype wire

// ### hdl/rfps_top.sv
// Contract
// - autoread returns next byte, advances head
// - drop short frames when enabled
// - drop FCS-error frames when enabled
// - drop broadcast frames when enabled
// - drop all group frames when enabled
// - sixteen-bit hash table, host read/write
// - valid flag shows current slot occupied
// - flag frames that carried VLAN tag
// - flag unsupported control frames
// - flag pause control frames
// - flag any control frame
// - flag one to seven trailing bits
// - separate broadcast and group address flags
// - flag type versus length field
// - flag length field mismatch
// - flag data too short for packet
// - group frame needs its hash bit set
// - current packet is always the oldest
// - end flag once last byte read
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module rfps_top #(
  parameter int BUF_DEPTH = rfps_pkg::BUF_DEPTH_DEF,
  parameter int SLOTS = rfps_pkg::SLOTS_DEF
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frames from the mac core
  input wire rfps_pkg::rfps_rx_s rx_in,
  input wire rfps_pkg::rfps_rx_end_s rx_end,
  // status
  output logic packet_waiting,
  output logic receive_busy
);
  localparam int AW = $clog2(BUF_DEPTH);
  localparam int SW = $clog2(SLOTS);

  if (BUF_DEPTH < 64 || (1 << AW) != BUF_DEPTH || BUF_DEPTH > 65536) begin : g_bad_depth
    $error("BUF_DEPTH must be a power of two from 64 to 65536");
  end
  if (SLOTS < 2 || (1 << SW) != SLOTS) begin : g_bad_slots
    $error("SLOTS must be a power of two of at least 2");
  end

  // data storage
  logic [7:0] mem [BUF_DEPTH];
  logic mem_we;
  logic [AW-1:0] mem_wa;

  // bus side state
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [3:0] filter_r, filter_nxt;
  logic [15:0] hash_r, hash_nxt;

  // buffer state
  logic [AW-1:0] head_r, head_nxt;
  logic [AW-1:0] tail_r, tail_nxt;
  logic [15:0] rdcnt_r, rdcnt_nxt;
  logic [SW-1:0] hslot_r, hslot_nxt;
  logic [SW-1:0] tslot_r, tslot_nxt;
  logic slot_vld_r [SLOTS], slot_vld_nxt [SLOTS];
  logic [AW-1:0] slot_start_r [SLOTS], slot_start_nxt [SLOTS];
  logic [15:0] slot_len_r [SLOTS], slot_len_nxt [SLOTS];
  rfps_pkg::rfps_info_s slot_info_r [SLOTS], slot_info_nxt [SLOTS];
  logic lost_r, lost_nxt;

  // frame in progress
  logic in_frame_r, in_frame_nxt;
  logic [AW-1:0] wp_r, wp_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic ovf_r, ovf_nxt;
  logic bc_r, bc_nxt;
  logic grp_r, grp_nxt;
  logic [31:0] crc_r, crc_nxt;

  logic [31:0] crc_in;
  logic [31:0] crc_step;

  rfps_crc_byte #(
    .POLY(rfps_pkg::CRC_POLY)
  ) u_crc (
    .crc_in(crc_in),
    .data(rx_in.data),
    .crc_out(crc_step)
  );

  // current packet view
  logic cur_vld, fully_read;
  logic [AW-1:0] cur_start;
  logic [15:0] cur_len;
  rfps_pkg::rfps_info_s cur_info;

  always_comb begin
    cur_vld = slot_vld_r[hslot_r];
    cur_start = slot_start_r[hslot_r];
    cur_len = slot_len_r[hslot_r];
    cur_info = slot_info_r[hslot_r];
    cur_info.slot_occupied = cur_vld;
    cur_info.rsvd = 2'h0;
    fully_read = cur_vld && (rdcnt_r == cur_len);
  end

  always_comb begin
    logic acc, capture, done, aligned, mapped, release_cur, flush, full;
    logic ovf_cur, bc_cur, grp_cur, runt, filt_drop, cap_drop;
    logic [AW-1:0] b_addr, oldest, used;
    logic [5:0] idx;
    logic [7:0] rd_byte;
    logic [15:0] cnt_base, length;
    logic [31:0] crc_cur;
    logic [3:0] hidx;
    acc = psel & penable;
    capture = acc & ~pready_r;
    done = acc & pready_r;
    idx = paddr[7:2];
    aligned = (paddr[1:0] == 2'h0);
    mapped = 1'b0;
    rd_byte = 8'h00;
    release_cur = 1'b0;
    flush = 1'b0;
    b_addr = rx_in.sof ? tail_r : wp_r;
    cnt_base = rx_in.sof ? 16'h0000 : cnt_r;
    crc_in = rx_in.sof ? rfps_pkg::CRC_INIT : crc_r;
    oldest = cur_vld ? cur_start : tail_r;
    used = b_addr - oldest;
    full = &used;
    ovf_cur = (rx_in.sof ? 1'b0 : ovf_r) | full;
    bc_cur = (rx_in.sof ? 1'b1 : bc_r) & (rx_in.data == 8'hFF);
    grp_cur = rx_in.sof ? rx_in.data[0] : grp_r;
    crc_cur = crc_step;
    length = cnt_base + 16'h0001;
    runt = length < rfps_pkg::MIN_FRAME_BYTES;
    hidx = 4'h0;
    filt_drop = 1'b0;
    cap_drop = 1'b0;
    mem_we = 1'b0;
    mem_wa = b_addr;

    pready_nxt = capture;
    pslverr_nxt = pslverr_r;
    prdata_nxt = prdata_r;
    filter_nxt = filter_r;
    hash_nxt = hash_r;
    head_nxt = head_r;
    tail_nxt = tail_r;
    rdcnt_nxt = rdcnt_r;
    hslot_nxt = hslot_r;
    tslot_nxt = tslot_r;
    slot_vld_nxt = slot_vld_r;
    slot_start_nxt = slot_start_r;
    slot_len_nxt = slot_len_r;
    slot_info_nxt = slot_info_r;
    lost_nxt = lost_r;
    in_frame_nxt = in_frame_r;
    wp_nxt = wp_r;
    cnt_nxt = cnt_r;
    ovf_nxt = ovf_r;
    bc_nxt = bc_r;
    grp_nxt = grp_r;
    crc_nxt = crc_r;

    // register read mux
    if (aligned) begin
      mapped = 1'b1;
      case (idx)
        rfps_pkg::IDX_AUTOREAD: begin
          rd_byte = (cur_vld && !fully_read) ? mem[head_r] : 8'h00;
        end
        rfps_pkg::IDX_HASH_HI: rd_byte = hash_r[15:8];
        rfps_pkg::IDX_HASH_LO: rd_byte = hash_r[7:0];
        rfps_pkg::IDX_FILTER: rd_byte = {4'h0, filter_r};
        rfps_pkg::IDX_CTRL: rd_byte = 8'h00;
        rfps_pkg::IDX_STATUS: begin
          rd_byte[rfps_pkg::STAT_FULLY_READ] = fully_read;
          rd_byte[rfps_pkg::STAT_BUSY] = in_frame_r;
        end
        rfps_pkg::IDX_INFO_HI: rd_byte = cur_vld ? cur_info[15:8] : 8'h00;
        rfps_pkg::IDX_INFO_LO: rd_byte = cur_vld ? cur_info[7:0] : 8'h00;
        default: begin
          mapped = 1'b0;
          rd_byte = 8'h00;
        end
      endcase
    end

    if (capture) begin
      prdata_nxt = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_nxt = ~mapped;
      // an autoread access pops one byte of the oldest packet, none once it is fully read or absent
      if (!pwrite && mapped && idx == rfps_pkg::IDX_AUTOREAD && cur_vld && !fully_read) begin
        head_nxt = head_r + 1'b1;
        rdcnt_nxt = rdcnt_r + 16'h0001;
      end
    end

    // writes land at the completing edge; info registers take none
    if (done && pwrite && mapped && pstrb[0]) begin
      case (idx)
        rfps_pkg::IDX_HASH_HI: hash_nxt[15:8] = pwdata[7:0];
        rfps_pkg::IDX_HASH_LO: hash_nxt[7:0] = pwdata[7:0];
        rfps_pkg::IDX_FILTER: filter_nxt = pwdata[3:0];
        rfps_pkg::IDX_CTRL: begin
          flush = pwdata[rfps_pkg::CTRL_FLUSH];
          release_cur = pwdata[rfps_pkg::CTRL_SKIP] | pwdata[rfps_pkg::CTRL_RELEASE];
        end
        default: begin
          flush = 1'b0;
        end
      endcase
    end

    // releasing skips unread bytes so the next oldest becomes current
    if (release_cur && cur_vld) begin
      slot_vld_nxt[hslot_r] = 1'b0;
      hslot_nxt = hslot_r + 1'b1;
      head_nxt = cur_start + cur_len[AW-1:0];
      rdcnt_nxt = 16'h0000;
    end

    // receive path
    if (rx_in.valid && (rx_in.sof || in_frame_r)) begin
      in_frame_nxt = ~rx_in.eof;
      ovf_nxt = ovf_cur;
      if (!ovf_cur) begin
        mem_we = 1'b1;
        wp_nxt = b_addr + 1'b1;
      end
      cnt_nxt = (&cnt_base) ? cnt_base : length;
      if (cnt_base < rfps_pkg::DEST_BYTES) begin
        crc_nxt = crc_step;
        bc_nxt = bc_cur;
        grp_nxt = grp_cur;
      end else begin
        crc_cur = crc_r;
        bc_cur = bc_r;
        grp_cur = grp_r;
      end
      if (rx_in.eof) begin
        hidx = crc_cur[3:0];
        filt_drop = (filter_r[rfps_pkg::FILT_DROP_SHORT] & runt)
                  | (filter_r[rfps_pkg::FILT_DROP_FCS] & rx_end.fcs_bad)
                  | (filter_r[rfps_pkg::FILT_DROP_BROADCAST_FLAG] & bc_cur)
                  | (grp_cur & ~bc_cur & filter_r[rfps_pkg::FILT_DROP_GROUP])
                  | (grp_cur & ~bc_cur & ~hash_r[hidx]);
        cap_drop = ovf_cur | slot_vld_r[tslot_r];
        if (cap_drop) begin
          lost_nxt = 1'b1;
        end else if (!filt_drop) begin
          slot_vld_nxt[tslot_r] = 1'b1;
          slot_start_nxt[tslot_r] = tail_r;
          slot_len_nxt[tslot_r] = length;
          slot_info_nxt[tslot_r].slot_occupied = 1'b1;
          slot_info_nxt[tslot_r].tagged_frame_seen = rx_end.vlan;
          slot_info_nxt[tslot_r].unsupported_ctrl_seen = rx_end.unsup;
          slot_info_nxt[tslot_r].pause_frame_seen = rx_end.pause;
          slot_info_nxt[tslot_r].ctrl_frame_seen = rx_end.ctrl;
          slot_info_nxt[tslot_r].trailing_bits_seen = rx_end.trailing;
          slot_info_nxt[tslot_r].broadcast_flag = bc_cur;
          slot_info_nxt[tslot_r].group_address_flag = grp_cur & ~bc_cur;
          slot_info_nxt[tslot_r].receive_good = ~rx_end.fcs_bad & ~rx_end.len_err & ~runt;
          slot_info_nxt[tslot_r].type_field = rx_end.type_field;
          slot_info_nxt[tslot_r].length_mismatch_flag = rx_end.len_err;
          slot_info_nxt[tslot_r].fcs_fail_flag = rx_end.fcs_bad;
          slot_info_nxt[tslot_r].rsvd = 2'h0;
          slot_info_nxt[tslot_r].too_short_flag = runt;
          slot_info_nxt[tslot_r].frame_lost_flag = lost_r;
          lost_nxt = 1'b0;
          tail_nxt = wp_nxt;
          tslot_nxt = tslot_r + 1'b1;
        end
      end
    end

    // flush wins over every buffer and slot update, including a frame ending now; lost_r keeps its new value
    if (flush) begin
      slot_vld_nxt = '{default: 1'b0};
      head_nxt = '0;
      tail_nxt = '0;
      hslot_nxt = '0;
      tslot_nxt = '0;
      rdcnt_nxt = 16'h0000;
      in_frame_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce && mem_we) begin
      mem[mem_wa] <= rx_in.data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      filter_r <= rfps_pkg::FILTER_RST;
      hash_r <= {rfps_pkg::HASH_HI_RST, rfps_pkg::HASH_LO_RST};
      head_r <= '0;
      tail_r <= '0;
      rdcnt_r <= 16'h0000;
      hslot_r <= '0;
      tslot_r <= '0;
      slot_vld_r <= '{default: 1'b0};
      slot_start_r <= '{default: '0};
      slot_len_r <= '{default: 16'h0000};
      slot_info_r <= '{default: '0};
      lost_r <= 1'b0;
      in_frame_r <= 1'b0;
      wp_r <= '0;
      cnt_r <= 16'h0000;
      ovf_r <= 1'b0;
      bc_r <= 1'b0;
      grp_r <= 1'b0;
      crc_r <= rfps_pkg::CRC_INIT;
    end else if (ce) begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      filter_r <= filter_nxt;
      hash_r <= hash_nxt;
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      rdcnt_r <= rdcnt_nxt;
      hslot_r <= hslot_nxt;
      tslot_r <= tslot_nxt;
      slot_vld_r <= slot_vld_nxt;
      slot_start_r <= slot_start_nxt;
      slot_len_r <= slot_len_nxt;
      slot_info_r <= slot_info_nxt;
      lost_r <= lost_nxt;
      in_frame_r <= in_frame_nxt;
      wp_r <= wp_nxt;
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
      bc_r <= bc_nxt;
      grp_r <= grp_nxt;
      crc_r <= crc_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign packet_waiting = cur_vld;
  assign receive_busy = in_frame_r;
endmodule : rfps_top
`default_nettype wire

// ### test/rfps_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rfps_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // receive side
  input wire rfps_pkg::rfps_rx_s rx_in,
  input wire logic receive_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence done_s;
    psel && penable && pready;
  endsequence
  one_wait_a: assert property (acc_s |=> done_s)
    else $error("access not answered after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable, 1))
    else $error("ready without access");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  write_zero_a: assert property (pready && pwrite |-> prdata == 32'h00000000)
    else $error("read data on write");
  misalign_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  busy_open_a: assert property (rx_in.valid && rx_in.sof && !rx_in.eof |=> receive_busy)
    else $error("busy not set at frame start");
  busy_close_a: assert property (rx_in.valid && rx_in.eof |=> !receive_busy)
    else $error("busy not cleared at frame end");
endmodule : rfps_checker
`default_nettype wire

// ### test/rfps_mac_src.sv
`timescale 1ns/1ns
`default_nettype none
module rfps_mac_src (
  // clock
  input wire logic clk_sys,
  // frame stream
  output rfps_pkg::rfps_rx_s rx_in,
  output rfps_pkg::rfps_rx_end_s rx_end
);
  logic [7:0] fb [0:127];
  initial begin
    rx_in = '0;
    rx_end = '0;
  end
  // frame facts only valid with the last byte; garbage elsewhere
  task automatic send(input int n, input rfps_pkg::rfps_rx_end_s e);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      rx_in <= '{valid: 1'b1, sof: i == 0, eof: i == n - 1, data: fb[i]};
      rx_end <= (i == n - 1) ? e : ~e;
    end
    @(posedge clk_sys);
    rx_in <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~fb[n - 1]};
    rx_end <= ~e;
  endtask : send
endmodule : rfps_mac_src
`default_nettype wire

// ### test/rfps_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rfps_top_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, packet_waiting, receive_busy;
  rfps_pkg::rfps_rx_s rx_in;
  rfps_pkg::rfps_rx_end_s rx_end;
  logic [31:0] seed = 32'h0000002A;
  int mismatches = 0;
  int n_checks = 0;
  logic [7:0] rd;
  logic err;
  logic [7:0] ra [0:6] = '{8'h40, 8'h38, 8'h3C, 8'h74, 8'h78, 8'h48, 8'h04};
  logic [7:0] rv [0:6] = '{8'h0C, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #4 clk_sys = ~clk_sys;
  rfps_top #(.BUF_DEPTH(256), .SLOTS(2)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
    .rx_end(rx_end), .packet_waiting(packet_waiting), .receive_busy(receive_busy));
  rfps_mac_src src (.clk_sys(clk_sys), .rx_in(rx_in), .rx_end(rx_end));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // hash index of the destination held in the first six frame bytes
  function automatic logic [3:0] hidx();
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int b = 0; b < 6; b++) begin
      for (int i = 0; i < 8; i++) begin
        c = (c >> 1) ^ ((c[0] ^ src.fb[b][i]) ? 32'hC704DD7B : 32'h00000000);
      end
    end
    return c[3:0];
  endfunction : hidx
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // kind 0 unicast, 1 broadcast, 2 group
  task automatic run(input int kind, input int n, input logic fcs, input logic [3:0] filt,
                     input logic hit, input logic acc);
    rfps_pkg::rfps_rx_end_s e;
    logic [31:0] r;
    logic [15:0] h;
    logic [7:0] hi;
    for (int i = 0; i < n; i++) src.fb[i] = 8'(xs());
    src.fb[0][0] = (kind == 2);
    if (kind == 2) src.fb[1] = 8'h00;
    if (kind == 1) for (int i = 0; i < 6; i++) src.fb[i] = 8'hFF;
    r = xs();
    e = r[7:0];
    e.fcs_bad = fcs;
    h = 16'h0001 << hidx();
    if (!hit) h = ~h;
    apb(1'b1, 8'h38, h[15:8]);
    apb(1'b1, 8'h3C, h[7:0]);
    apb(1'b1, 8'h40, {4'h0, filt});
    apb(1'b0, 8'h38, 8'h00);
    check(rd, h[15:8]);
    apb(1'b0, 8'h3C, 8'h00);
    check(rd, h[7:0]);
    src.send(n, e);
    repeat (2) @(posedge clk_sys);
    check({7'h00, packet_waiting}, {7'h00, acc});
    hi = acc ? {1'b1, e.vlan, e.unsup, e.pause, e.ctrl, e.trailing, kind == 1, kind == 2} : 8'h00;
    apb(1'b1, 8'h74, 8'hFF);
    apb(1'b0, 8'h74, 8'h00);
    check(rd, hi);
    apb(1'b0, 8'h78, 8'h00);
    check(rd & 8'h7F, acc ? {1'b0, e.type_field, e.len_err, fcs, 2'h0, n < 64, 1'b0} : 8'h00);
    if (acc) begin
      apb(1'b0, 8'h48, 8'h00);
      check(rd, 8'h00);
      for (int i = 0; i < n; i++) begin
        apb(1'b0, 8'h04, 8'h00);
        check(rd, src.fb[i]);
      end
      apb(1'b0, 8'h48, 8'h00);
      check(rd, 8'h02);
      apb(1'b0, 8'h04, 8'h00);
      check(rd, 8'h00);
      apb(1'b1, 8'h44, 8'h04);
      apb(1'b0, 8'h74, 8'h00);
      check(rd, 8'h00);
    end
  endtask : run

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 8'h00);
      check(rd, rv[i]);
    end
    apb(1'b0, 8'h80, 8'h00);
    check({err, rd[6:0]}, 8'h80);
    apb(1'b1, 8'h41, 8'hFF);
    check({7'h00, err}, 8'h01);
    apb(1'b1, 8'h40, 8'hFF);
    apb(1'b0, 8'h40, 8'h00);
    check(rd, 8'h0F);
    pstrb <= 4'h0;
    apb(1'b1, 8'h40, 8'h00);
    pstrb <= 4'hF;
    apb(1'b0, 8'h40, 8'h00);
    check(rd, 8'h0F);
    run(0, 64, 1'b0, 4'hC, 1'b1, 1'b1);
    run(0, 63, 1'b0, 4'h8, 1'b1, 1'b0);
    run(0, 63, 1'b0, 4'h0, 1'b1, 1'b1);
    run(0, 64, 1'b1, 4'h4, 1'b1, 1'b0);
    run(0, 64, 1'b1, 4'h0, 1'b1, 1'b1);
    run(1, 64, 1'b0, 4'h2, 1'b1, 1'b0);
    run(1, 64, 1'b0, 4'h0, 1'b1, 1'b1);
    run(2, 64, 1'b0, 4'h1, 1'b1, 1'b0);
    run(2, 64, 1'b0, 4'h0, 1'b1, 1'b1);
    run(2, 64, 1'b0, 4'h0, 1'b0, 1'b0);
    for (int j = 0; j < 6; j++) run(0, 64 + int'(xs() % 37), 1'b0, 4'(xs()) & 4'hE, 1'b1, 1'b1);
    // two slots: third frame lost, oldest presented first
    for (int j = 1; j < 4; j++) begin
      src.fb[0] = 8'(j << 4);
      src.send(64, '0);
    end
    repeat (2) @(posedge clk_sys);
    apb(1'b0, 8'h04, 8'h00);
    check(rd, 8'h10);
    apb(1'b1, 8'h44, 8'h02);
    apb(1'b0, 8'h04, 8'h00);
    check(rd, 8'h20);
    apb(1'b1, 8'h44, 8'h02);
    src.send(64, '0);
    repeat (2) @(posedge clk_sys);
    apb(1'b0, 8'h78, 8'h00);
    check({7'h00, rd[0]}, 8'h01);
    apb(1'b1, 8'h44, 8'h01);
    apb(1'b0, 8'h74, 8'h00);
    check(rd, 8'h00);
    check({7'h00, packet_waiting}, 8'h00);
    final_report();
  end
  initial begin
    #800000;
    mismatches++;
    final_report();
  end
endmodule : rfps_top_tb
bind rfps_top rfps_checker chk (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_in(rx_in), .receive_busy(receive_busy));
`default_nettype wire
